// ==== inc/tcc_consts.svh ====
// register map, field positions, codes and reset values of the capture/compare channels
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_NCH         3
`define TCC_NSUB        6
`define TCC_OFF_CTL     8'h00
`define TCC_OFF_RELOAD  8'h04
`define TCC_OFF_COUNT   8'h08
`define TCC_OFF_PAIR    8'h0C
`define TCC_OFF_INTEN   8'h10
`define TCC_OFF_STAT    8'h14
`define TCC_OFF_SWEVG   8'h18
`define TCC_OFF_CFG     8'h20
`define TCC_OFF_VAL     8'h40
`define TCC_CTL_RUN     0
`define TCC_PAIR_ROS    8
`define TCC_PAIR_IOS    9
`define TCC_PAIR_POE    10
`define TCC_PAIR_DT     16
`define TCC_INTEN_DE    8
`define TCC_STAT_OVF    8
`define TCC_SRC_OUT     3'h0
`define TCC_SRC_OWN     3'h1
`define TCC_SRC_NBR     3'h2
`define TCC_SRC_TRG     3'h3
`define TCC_ACT_FROZEN  4'h0
`define TCC_ACT_SET     4'h1
`define TCC_ACT_CLR     4'h2
`define TCC_ACT_TGL     4'h3
`define TCC_ACT_FLOW    4'h4
`define TCC_ACT_FHIGH   4'h5
`define TCC_ACT_PWM0    4'h6
`define TCC_ACT_PWM1    4'h7
`define TCC_PAIR_IND    2'h0
`define TCC_PAIR_CMP    2'h3
`define TCC_RELOAD_RST  16'hFFFF
`endif

// ==== inc/tcc_pkg.sv ====
// types of the capture/compare channel block
package tcc_pkg;
`include "tcc_consts.svh"
    typedef struct packed {
        logic       en;
        logic       shd;
        logic       pol;
        logic [3:0] act;
        logic [1:0] psc;
        logic [3:0] filt;
        logic [2:0] src;
    } tcc_cfg_t;
    typedef struct packed {
        logic [15:0]       cnt;
        logic              run;
        logic [15:0]       reload;
        logic [2:0][1:0]   pair;
        logic              run_state_off;
        logic              idle_state_off;
        logic              primary_output_enable;
        logic [7:0]        dt;
        logic [5:0]        ie;
        logic [5:0]        de;
        logic [5:0]        flag;
        logic [5:0]        ovf;
        tcc_cfg_t [5:0]    cfg;
        logic [5:0][15:0]  val;
        logic [5:0][15:0]  cmp;
        logic [5:0]        prep;
        logic [6:0]        sy1;
        logic [6:0]        sy2;
        logic [5:0]        filt_o;
        logic [5:0][3:0]   fcnt;
        logic [5:0]        sel_d;
        logic [5:0][2:0]   pcnt;
        logic [2:0][7:0]   dtc;
        logic [2:0]        ch_out;
        logic [2:0]        pt_out;
        logic [5:0]        irq;
        logic [5:0]        dma;
        logic              wr_pend;
        logic [7:0]        wr_addr;
        logic [31:0]       rdata;
        logic              ready;
    } tcc_state_t;
endpackage

// ==== hdl/tcc_channels.sv ====
// three capture/compare channels with partners, shared up counter, AHB-Lite registers
`timescale 1ns/1ns
`include "tcc_consts.svh"
module tcc_channels
    import tcc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic [2:0]  CH_IN,
    input  wire logic [2:0]  PT_IN,
    input  wire logic        TRIG_IN,
    output logic      [2:0]  CH_OUT,
    output logic      [2:0]  PT_OUT,
    output logic      [5:0]  IRQ_REQ,
    output logic      [5:0]  DMA_REQ
);
    tcc_state_t  s_r;
    tcc_state_t  s_nxt;
    logic [5:0]  cap_v;
    logic [5:0]  match_v;
    logic [5:0]  sig_v;
    logic [5:0]  soft_v;
    logic        upd;
    logic        addr_ok;

    // input used by source code 010: channel 1 takes input 0, partners take their main pin
    function automatic int nbr(input int k);
        int r;
        r = (k < `TCC_NCH) ? ((k + 2) % `TCC_NCH) : (k - `TCC_NCH);
        return r;
    endfunction

    function automatic logic [31:0] rd_mux(input tcc_state_t st, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `TCC_OFF_CTL:    d[`TCC_CTL_RUN] = st.run;
            `TCC_OFF_RELOAD: d[15:0] = st.reload;
            `TCC_OFF_COUNT:  d[15:0] = st.cnt;
            `TCC_OFF_PAIR: begin
                d[5:0] = st.pair;
                d[`TCC_PAIR_ROS] = st.run_state_off;
                d[`TCC_PAIR_IOS] = st.idle_state_off;
                d[`TCC_PAIR_POE] = st.primary_output_enable;
                d[`TCC_PAIR_DT +: 8] = st.dt;
            end
            `TCC_OFF_INTEN: begin
                d[5:0] = st.ie;
                d[`TCC_INTEN_DE +: 6] = st.de;
            end
            `TCC_OFF_STAT: begin
                d[5:0] = st.flag;
                d[`TCC_STAT_OVF +: 6] = st.ovf;
            end
            default: begin
                for (int k = 0; k < `TCC_NSUB; k++) begin
                    if (a == `TCC_OFF_CFG + 8'(4 * k)) d[15:0] = st.cfg[k];
                    if (a == `TCC_OFF_VAL + 8'(4 * k)) d[15:0] = st.val[k];
                end
            end
        endcase
        return d;
    endfunction

    always_comb begin
        logic       in_mode;
        logic       edge_q;
        logic       qual;
        logic [2:0] lim;
        logic       m_en;
        logic       p_en;
        logic       dt_ok;
        logic       off_m;
        logic       off_p;
        s_nxt = s_r;
        in_mode = 1'b0;
        edge_q = 1'b0;
        qual = 1'b0;
        lim = 3'h0;
        m_en = 1'b0;
        p_en = 1'b0;
        dt_ok = 1'b0;
        off_m = 1'b0;
        off_p = 1'b0;
        cap_v = 6'h00;
        match_v = 6'h00;
        sig_v = 6'h00;
        upd = 1'b0;
        // only the second stage feeds the filters
        s_nxt.sy1 = {TRIG_IN, PT_IN, CH_IN};
        s_nxt.sy2 = s_r.sy1;
        if (s_r.run) begin
            if (s_r.cnt >= s_r.reload) begin
                s_nxt.cnt = 16'h0000;
                upd = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
            end
        end
        // bus data phase: writes land one cycle after their address phase
        soft_v = 6'h00;
        if (s_r.wr_pend) begin
            case (s_r.wr_addr)
                `TCC_OFF_CTL:    s_nxt.run = HWDATA[`TCC_CTL_RUN];
                `TCC_OFF_RELOAD: s_nxt.reload = HWDATA[15:0];
                `TCC_OFF_PAIR: begin
                    s_nxt.pair = HWDATA[5:0];
                    s_nxt.run_state_off = HWDATA[`TCC_PAIR_ROS];
                    s_nxt.idle_state_off = HWDATA[`TCC_PAIR_IOS];
                    s_nxt.primary_output_enable = HWDATA[`TCC_PAIR_POE];
                    s_nxt.dt = HWDATA[`TCC_PAIR_DT +: 8];
                end
                `TCC_OFF_INTEN: begin
                    s_nxt.ie = HWDATA[5:0];
                    s_nxt.de = HWDATA[`TCC_INTEN_DE +: 6];
                end
                `TCC_OFF_STAT: begin
                    s_nxt.flag = s_r.flag & ~HWDATA[5:0];
                    s_nxt.ovf = s_r.ovf & ~HWDATA[`TCC_STAT_OVF +: 6];
                end
                `TCC_OFF_SWEVG: soft_v = HWDATA[5:0];
                default: begin
                    for (int k = 0; k < `TCC_NSUB; k++) begin
                        if (s_r.wr_addr == `TCC_OFF_CFG + 8'(4 * k)) begin
                            s_nxt.cfg[k] = tcc_cfg_t'(HWDATA[15:0]);
                        end
                        if (s_r.wr_addr == `TCC_OFF_VAL + 8'(4 * k) &&
                            s_r.cfg[k].src == `TCC_SRC_OUT) begin
                            s_nxt.val[k] = HWDATA[15:0];
                        end
                    end
                end
            endcase
        end
        for (int k = 0; k < `TCC_NSUB; k++) begin
            // filter: output follows only after filt+1 equal differing samples
            if (s_r.sy2[k] == s_r.filt_o[k]) begin
                s_nxt.fcnt[k] = 4'h0;
            end else if (s_r.fcnt[k] >= s_r.cfg[k].filt) begin
                s_nxt.filt_o[k] = s_r.sy2[k];
                s_nxt.fcnt[k] = 4'h0;
            end else begin
                s_nxt.fcnt[k] = s_r.fcnt[k] + 4'h1;
            end
            case (s_r.cfg[k].src)
                `TCC_SRC_NBR: sig_v[k] = s_r.filt_o[nbr(k)];
                `TCC_SRC_TRG: sig_v[k] = s_r.sy2[6];
                default:      sig_v[k] = s_r.filt_o[k];
            endcase
            s_nxt.sel_d[k] = sig_v[k];
            edge_q = s_r.cfg[k].pol ? (s_r.sel_d[k] & ~sig_v[k])
                                    : (~s_r.sel_d[k] & sig_v[k]);
            in_mode = (s_r.cfg[k].src != `TCC_SRC_OUT);
            // each sub-channel captures on its own, whatever the pairing code
            qual = in_mode & s_r.cfg[k].en & edge_q;
            lim = 3'((4'h1 << s_r.cfg[k].psc) - 4'h1);
            if (!(in_mode && s_r.cfg[k].en)) begin
                s_nxt.pcnt[k] = 3'h0;
            end else if (qual) begin
                if (s_r.pcnt[k] >= lim) begin
                    s_nxt.pcnt[k] = 3'h0;
                    cap_v[k] = 1'b1;
                end else begin
                    s_nxt.pcnt[k] = s_r.pcnt[k] + 3'h1;
                end
            end
            if (cap_v[k]) begin
                s_nxt.val[k] = s_r.cnt;
            end
            match_v[k] = !in_mode && s_r.run && (s_r.cnt == s_r.cmp[k]);
            case (s_r.cfg[k].act)
                `TCC_ACT_SET:   if (match_v[k]) s_nxt.prep[k] = 1'b1;
                `TCC_ACT_CLR:   if (match_v[k]) s_nxt.prep[k] = 1'b0;
                `TCC_ACT_TGL:   if (match_v[k]) s_nxt.prep[k] = ~s_r.prep[k];
                `TCC_ACT_FLOW:  s_nxt.prep[k] = 1'b0;
                `TCC_ACT_FHIGH: s_nxt.prep[k] = 1'b1;
                `TCC_ACT_PWM0:  s_nxt.prep[k] = (s_r.cnt < s_r.cmp[k]);
                `TCC_ACT_PWM1:  s_nxt.prep[k] = (s_r.cnt >= s_r.cmp[k]);
                default:        s_nxt.prep[k] = s_r.prep[k];
            endcase
            // with shadowing a value written in the wrapping cycle waits one more period
            if (!s_r.cfg[k].shd) begin
                s_nxt.cmp[k] = s_nxt.val[k];
            end else if (upd) begin
                s_nxt.cmp[k] = s_r.val[k];
            end
            // hardware set wins over a same-cycle software clear
            if (cap_v[k] | match_v[k] | soft_v[k]) s_nxt.flag[k] = 1'b1;
            if (cap_v[k] && s_r.flag[k]) s_nxt.ovf[k] = 1'b1;
            s_nxt.irq[k] = (cap_v[k] | match_v[k] | soft_v[k]) & s_r.ie[k];
            s_nxt.dma[k] = (cap_v[k] | match_v[k] | soft_v[k]) & s_r.de[k];
        end
        for (int c = 0; c < `TCC_NCH; c++) begin
            if (s_nxt.prep[c] != s_r.prep[c]) begin
                s_nxt.dtc[c] = 8'h00;
            end else if (s_r.dtc[c] < s_r.dt) begin
                s_nxt.dtc[c] = s_r.dtc[c] + 8'h01;
            end
            dt_ok = (s_r.dtc[c] >= s_r.dt);
            m_en = s_r.cfg[c].en && (s_r.cfg[c].src == `TCC_SRC_OUT);
            p_en = s_r.cfg[c + 3].en && (s_r.cfg[c + 3].src == `TCC_SRC_OUT);
            // a disabled pin drives its inactive level when the selected off state bit is set, and low when it is clear
            off_m = (s_r.primary_output_enable ? s_r.run_state_off : s_r.idle_state_off) & s_r.cfg[c].pol;
            off_p = (s_r.primary_output_enable ? s_r.run_state_off : s_r.idle_state_off) & s_r.cfg[c + 3].pol;
            if (s_r.pair[c] == `TCC_PAIR_CMP && m_en && p_en) begin
                if (!s_r.primary_output_enable) begin
                    s_nxt.ch_out[c] = off_m;
                    s_nxt.pt_out[c] = off_p;
                end else begin
                    s_nxt.ch_out[c] = (s_r.prep[c] & dt_ok) ^ s_r.cfg[c].pol;
                    s_nxt.pt_out[c] = (~s_r.prep[c] & dt_ok) ^ s_r.cfg[c + 3].pol;
                end
            end else if (s_r.pair[c] == `TCC_PAIR_CMP) begin
                s_nxt.ch_out[c] = m_en ? (s_r.prep[c] ^ s_r.cfg[c].pol) : off_m;
                s_nxt.pt_out[c] = p_en ? (~s_r.prep[c] ^ s_r.cfg[c + 3].pol) : off_p;
            end else begin
                s_nxt.ch_out[c] = m_en ? (s_r.prep[c] ^ s_r.cfg[c].pol) : off_m;
                s_nxt.pt_out[c] = p_en ? (s_r.prep[c + 3] ^ s_r.cfg[c + 3].pol) : off_p;
            end
        end
        // read data taken after this cycle's updates so a write-then-read sees the new value
        addr_ok = HSEL && HTRANS[1] && HREADY;
        s_nxt.wr_pend = addr_ok && HWRITE;
        s_nxt.wr_addr = HADDR[7:0];
        s_nxt.rdata = (addr_ok && !HWRITE) ? rd_mux(s_nxt, HADDR[7:0]) : 32'h0000_0000;
        s_nxt.ready = 1'b1;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_r <= '0;
            s_r.reload <= `TCC_RELOAD_RST;
            s_r.ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign HRDATA = s_r.rdata;
    assign HREADYOUT = s_r.ready;
    assign HRESP = 1'b0;
    assign CH_OUT = s_r.ch_out;
    assign PT_OUT = s_r.pt_out;
    assign IRQ_REQ = s_r.irq;
    assign DMA_REQ = s_r.dma;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    AST_CNT_WRAP: assert property (
        s_r.run && s_r.cnt >= s_r.reload |=> s_r.cnt == 16'h0000)
        else $error("counter did not restart at reload");
    AST_CNT_INC: assert property (
        s_r.run && s_r.cnt < s_r.reload |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
        else $error("counter did not advance by one");
    AST_CAP_VAL: assert property (
        cap_v[0] |=> s_r.val[0] == $past(s_r.cnt) && s_r.flag[0])
        else $error("capture lost counter value or flag");
    AST_OVF: assert property (
        cap_v[1] && s_r.flag[1] |=> s_r.ovf[1])
        else $error("overcapture not flagged");
    AST_IRQ_CAP: assert property (
        cap_v[0] && s_r.ie[0] |=> IRQ_REQ[0]
        ##1 (!IRQ_REQ[0] || $past(cap_v[0] | match_v[0] | soft_v[0])))
        else $error("capture interrupt request missing");
    AST_DMA_GATE: assert property (
        DMA_REQ[3] |-> $past(s_r.de[3]))
        else $error("dma request without enable");
    AST_SOFT: assert property (
        s_r.wr_pend && s_r.wr_addr == `TCC_OFF_SWEVG && HWDATA[2] && s_r.ie[2]
        |=> IRQ_REQ[2] && s_r.flag[2])
        else $error("software event gave no request");
    AST_NOCAP_DIS: assert property (
        !s_r.cfg[0].en |-> !cap_v[0])
        else $error("capture while disabled");
    AST_RO_VAL: assert property (
        s_r.wr_pend && s_r.wr_addr == `TCC_OFF_VAL && s_r.cfg[0].src != `TCC_SRC_OUT
        && !cap_v[0] |=> s_r.val[0] == $past(s_r.val[0]))
        else $error("input channel value was written");
    AST_SRC_NBR: assert property (
        s_r.cfg[1].src == `TCC_SRC_NBR |-> sig_v[1] == s_r.filt_o[0])
        else $error("channel 1 did not select input 0");
    AST_FILT: assert property (
        s_r.filt_o[0] != $past(s_r.filt_o[0]) |-> $past(s_r.fcnt[0]) >= $past(s_r.cfg[0].filt))
        else $error("filter changed too early");
    AST_PWM0: assert property (
        s_r.cfg[0].act == `TCC_ACT_PWM0 |=> s_r.prep[0] == ($past(s_r.cnt) < $past(s_r.cmp[0])))
        else $error("pwm0 prepare wrong");
    AST_TGL: assert property (
        s_r.cfg[0].act == `TCC_ACT_TGL && match_v[0] |=> s_r.prep[0] != $past(s_r.prep[0]))
        else $error("toggle on match missing");
    AST_INDEP: assert property (
        s_r.pair[0] == `TCC_PAIR_IND && s_r.cfg[0].en && s_r.cfg[0].src == `TCC_SRC_OUT
        |=> CH_OUT[0] == ($past(s_r.prep[0]) ^ $past(s_r.cfg[0].pol)))
        else $error("main pin does not follow prepare and polarity");
    AST_COMP: assert property (
        s_r.pair[0] == `TCC_PAIR_CMP && s_r.primary_output_enable && s_r.dt == 8'h00
        && s_r.cfg[0].en && s_r.cfg[3].en && s_r.cfg[0].src == `TCC_SRC_OUT
        && s_r.cfg[3].src == `TCC_SRC_OUT
        |=> (CH_OUT[0] ^ $past(s_r.cfg[0].pol)) != (PT_OUT[0] ^ $past(s_r.cfg[3].pol)))
        else $error("partner pin is not the inverse");
    AST_POE_OFF: assert property (
        s_r.pair[1] == `TCC_PAIR_CMP && !s_r.primary_output_enable && s_r.cfg[1].en && s_r.cfg[4].en
        && s_r.cfg[1].src == `TCC_SRC_OUT && s_r.cfg[4].src == `TCC_SRC_OUT
        |=> CH_OUT[1] == $past(s_r.idle_state_off & s_r.cfg[1].pol))
        else $error("pins not in idle level");
    AST_SHADOW: assert property (
        !s_r.cfg[2].shd |=> s_r.cmp[2] == s_r.val[2])
        else $error("unshadowed compare value not applied");

    // further checks on the bus response and on channels 0 and 2
    AST_READY: assert property (
        HREADYOUT && !HRESP)
        else $error("bus slave inserted a wait or an error");
    AST_PT_INDEP: assert property (
        s_r.pair[0] == `TCC_PAIR_IND && s_r.cfg[3].en && s_r.cfg[3].src == `TCC_SRC_OUT
        |=> PT_OUT[0] == ($past(s_r.prep[3]) ^ $past(s_r.cfg[3].pol)))
        else $error("partner pin does not follow its own prepare");
    AST_PWM1: assert property (
        s_r.cfg[2].act == `TCC_ACT_PWM1 |=> s_r.prep[2] == ($past(s_r.cnt) >= $past(s_r.cmp[2])))
        else $error("pwm1 prepare wrong");
    AST_SET: assert property (
        s_r.cfg[2].act == `TCC_ACT_SET && match_v[2] |=> s_r.prep[2])
        else $error("set on match missing");
    AST_FLAG_MATCH: assert property (
        match_v[0] |=> s_r.flag[0])
        else $error("match did not set the flag");
    AST_DMA_MATCH: assert property (
        match_v[0] && s_r.de[0] |=> DMA_REQ[0])
        else $error("match dma request missing");
    AST_COMP2: assert property (
        s_r.pair[2] == `TCC_PAIR_CMP && s_r.primary_output_enable && s_r.dt == 8'h00
        && s_r.cfg[2].en && s_r.cfg[5].en && s_r.cfg[2].src == `TCC_SRC_OUT
        && s_r.cfg[5].src == `TCC_SRC_OUT
        |=> (CH_OUT[2] ^ $past(s_r.cfg[2].pol)) != (PT_OUT[2] ^ $past(s_r.cfg[5].pol)))
        else $error("partner pin 2 is not the inverse");

    COV_CAPTURE: cover property (cap_v[0] ##[1:20] cap_v[0]);
    COV_OVERCAP: cover property (cap_v[1] && s_r.flag[1]);
    COV_PWM1: cover property (s_r.cfg[0].act == `TCC_ACT_PWM1 && match_v[0]);
    COV_COMP: cover property (s_r.pair[0] == `TCC_PAIR_CMP && s_r.primary_output_enable && CH_OUT[0] != PT_OUT[0]);
    COV_COMP2: cover property (s_r.pair[2] == `TCC_PAIR_CMP && s_r.primary_output_enable && PT_OUT[2]);
endmodule

// ==== dv/tcc_pins_model.sv ====
// signal sources standing on the capture input pins
`timescale 1ns/1ns
module tcc_pins_model (
    input  wire logic       CLK,
    output logic      [2:0] ch_in,
    output logic      [2:0] pt_in,
    output logic            trig_in
);
    // idle pins sit low as if pulled down
    initial begin
        ch_in = 3'h0;
        pt_in = 3'h0;
        trig_in = 1'b0;
    end

    // each level is held well past sync plus filter so the edge is qualified
    task automatic pulse(input int grp, input int idx);
        @(posedge CLK);
        if (grp == 0) ch_in[idx] <= 1'b1; else pt_in[idx] <= 1'b1;
        repeat (6) @(posedge CLK);
        if (grp == 0) ch_in[idx] <= 1'b0; else pt_in[idx] <= 1'b0;
        repeat (6) @(posedge CLK);
    endtask
endmodule

// ==== dv/tcc_channels_bench.sv ====
// register-driven bench for the capture/compare channels
`timescale 1ns/1ns
`include "tcc_consts.svh"
module tcc_channels_bench;
    import tcc_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [2:0]  ch_in, pt_in, ch_out, pt_out;
    logic        trig_in;
    logic [5:0]  irq_req, dma_req;
    logic        prev0 = 1'b0;
    logic [31:0] rd, c;
    int          errors = 0, samples_checked = 0, cycles = 0, flips = 0, highs;
    int          irq_cnt[6] = '{default: 0}, dma_cnt[6] = '{default: 0};
    logic [3:0]  act_t[7] = '{`TCC_ACT_SET, `TCC_ACT_CLR, `TCC_ACT_PWM0, `TCC_ACT_PWM0,
                              `TCC_ACT_PWM0, `TCC_ACT_PWM1, `TCC_ACT_PWM1};
    logic [15:0] val_t[7] = '{16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0020, 16'h0020,
                              16'h0003};
    logic        pol_t[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    int          hi_t[7] = '{10, 0, 3, 7, 10, 0, 7};

    always #20 clk = ~clk;

    tcc_channels i_tcc_channels (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CH_IN(ch_in), .PT_IN(pt_in),
        .TRIG_IN(trig_in), .CH_OUT(ch_out), .PT_OUT(pt_out), .IRQ_REQ(irq_req),
        .DMA_REQ(dma_req));
    tcc_pins_model i_tcc_pins_model (.CLK(clk), .ch_in(ch_in), .pt_in(pt_in),
        .trig_in(trig_in));

    always @(posedge clk) begin
        cycles++;
        for (int i = 0; i < 6; i++) begin
            if (irq_req[i] === 1'b1) irq_cnt[i]++;
            if (dma_req[i] === 1'b1) dma_cnt[i]++;
        end
        // pins are unknown before the first reset edge, so count only once out of reset
        if (arst_n && ch_out[0] !== prev0) flips++;
        prev0 = ch_out[0];
        // far beyond the few hundred cycles the sequence needs
        if (cycles > 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] r);
        ahb(1'b0, a, 32'h0, r);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rdr(`TCC_OFF_RELOAD, rd); chk("reload", 32'h0000FFFF, rd);
        rdr(8'h1C, rd); chk("unmapped", 32'h0, rd);
        $display("reset test done");
        // configure fully before the run bit, as software must
        wr(`TCC_OFF_RELOAD, 32'h9);
        wr(`TCC_OFF_VAL, 32'h3);
        wr(`TCC_OFF_CFG, 32'h8600);
        wr(`TCC_OFF_INTEN, 32'h0101);
        wr(`TCC_OFF_CTL, 32'h1);
        for (int k = 0; k < 7; k++) begin
            wr(`TCC_OFF_VAL + 8'h08, {16'h0, val_t[k]});
            wr(`TCC_OFF_CFG + 8'h08, {16'h0, 2'b10, pol_t[k], act_t[k], 9'h0});
            repeat (25) @(posedge clk);
            highs = 0;
            repeat (10) begin
                @(posedge clk);
                highs += (ch_out[2] === 1'b1);
            end
            chk("duty", hi_t[k], highs);
        end
        wr(`TCC_OFF_CTL, 32'h0);
        repeat (4) @(posedge clk);
        rdr(`TCC_OFF_COUNT, c); chk("count bound", 1, c <= 32'h9);
        chk("toggles", irq_cnt[0], flips);
        chk("irq0 seen", 1, irq_cnt[0] > 0);
        chk("dma0", irq_cnt[0], dma_cnt[0]);
        rdr(`TCC_OFF_STAT, rd); chk("flag0", 1, rd[0]);
        $display("compare test done");
        wr(`TCC_OFF_STAT, 32'h3F3F);
        wr(`TCC_OFF_INTEN, 32'h0A0A);
        wr(`TCC_OFF_CFG + 8'h0C, 32'h8001);
        wr(`TCC_OFF_CFG + 8'h04, 32'h8002);
        i_tcc_pins_model.pulse(1, 0);
        i_tcc_pins_model.pulse(0, 0);
        rdr(`TCC_OFF_VAL + 8'h0C, rd); chk("capture", c, rd);
        rdr(`TCC_OFF_STAT, rd); chk("flags", 32'h0A, rd);
        i_tcc_pins_model.pulse(1, 0);
        rdr(`TCC_OFF_STAT, rd); chk("overcapture", 32'h080A, rd);
        wr(`TCC_OFF_VAL + 8'h0C, 32'h1234);
        rdr(`TCC_OFF_VAL + 8'h0C, rd); chk("value locked", c, rd);
        wr(`TCC_OFF_CFG + 8'h0C, 32'h0001);
        i_tcc_pins_model.pulse(1, 0);
        chk("irq3", 2, irq_cnt[3]);
        chk("dma3", 2, dma_cnt[3]);
        chk("irq1", 1, irq_cnt[1]);
        $display("capture test done");
        wr(`TCC_OFF_INTEN, 32'h2020);
        wr(`TCC_OFF_SWEVG, 32'h20);
        repeat (3) @(posedge clk);
        chk("soft irq", 1, irq_cnt[5]);
        chk("soft dma", 1, dma_cnt[5]);
        $display("soft event test done");
        wr(`TCC_OFF_PAIR, 32'h0430);
        wr(`TCC_OFF_CFG + 8'h14, 32'h8000);
        wr(`TCC_OFF_CFG + 8'h08, 32'h8A00);
        repeat (3) @(posedge clk);
        chk("comp main high", 1, ch_out[2]);
        chk("comp partner low", 0, pt_out[2]);
        wr(`TCC_OFF_CFG + 8'h08, 32'h8800);
        repeat (3) @(posedge clk);
        chk("comp main low", 0, ch_out[2]);
        chk("comp partner high", 1, pt_out[2]);
        wr(`TCC_OFF_PAIR, 32'h0030);
        repeat (3) @(posedge clk);
        chk("idle partner", 0, pt_out[2]);
        chk("hresp", 0, hresp);
        $display("complementary test done");
        conclude();
    end
endmodule
